// File: inc/intc_pkg.sv
package intc_pkg;
  // ==========================================
  // Sizes
  localparam int NSRC = 21;
  localparam int ONE_BITS = 16;
  localparam int TWO_BITS = NSRC - ONE_BITS;
  localparam int PIN_LO = 1;
  localparam int PIN_HI = 3;

  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_REQ_ONE = 8'h00;
  localparam logic [7:0] OFS_REQ_TWO = 8'h04;
  localparam logic [7:0] OFS_EN_ONE = 8'h08;
  localparam logic [7:0] OFS_EN_TWO = 8'h0c;
  localparam logic [7:0] OFS_PIN_FUNC = 8'h10;
  localparam logic [7:0] OFS_EDGE_SEL = 8'h14;
  localparam logic [7:0] OFS_PIN_REQ = 8'h18;
  localparam logic [7:0] OFS_PIN_EN = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ==========================================
  // Reset values
  localparam logic [NSRC-1:0] RST_FLAGS = 21'h00_0000;
  localparam logic [3:1] RST_PIN = 3'h0;
  localparam logic [3:1] PIN_IDLE = 3'h7;

  // ==========================================
  // Timing in states
  localparam logic [3:0] SAVE_STATES = 4'h4;
  localparam logic [3:0] VEC_STATES = 4'h2;
  localparam logic [3:0] IFETCH_STATES = 4'h4;
  localparam logic [3:0] INTERNAL_STATES = 4'h4;
  localparam logic [3:0] WAIT_MAX = 4'hd;

  // ==========================================
  // Vectors and stack slots
  localparam logic [4:0] VEC_FIRST = 5'h09;
  localparam logic [4:0] VEC_LAST = 5'h17;
  localparam logic [4:0] VEC_PIN_ONE = 5'h05;
  localparam logic [15:0] PC_SLOT = 16'h0002;
  localparam logic [15:0] CODE_SLOT = 16'h0004;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_SAVE = 3'h2,
    ST_VFETCH = 3'h3,
    ST_IFETCH = 3'h4,
    ST_INTERNAL = 3'h5
  } st_t;

  function automatic logic [4:0] vec_of(input int i);
    if (i > int'(VEC_LAST - VEC_FIRST)) begin
      return VEC_LAST;
    end
    return 5'(int'(VEC_FIRST) + i);
  endfunction : vec_of
endpackage : intc_pkg

// File: src/intc_core.sv
// Contract
// - Twenty-one peripheral sources set own flags
// - Cleared enable hides that source only
// - Mask bit set blocks all internal requests
// - Internal sources use vectors 9 to 23
// - Highest priority chosen, others stay pending
// - Accept only while mask bit is zero
// - Finish instruction, push counter and codes
// - Mask bit set on exception entry
// - Vector address generated for accepted source
// - Colliding clear delays entry until done
// - Instruction wait is 1 to 13 states
// - Entry takes 4, 2, 4, 4 states
// - Word accesses force address bit zero
// - Codes saved as word, even byte restored
// - Function 0 to 1, pin low, falling-select
// - Function 1 to 0, pin low, rising-select
// - Clear right after function write ignored
// - Flags clear only by writing zero
// - Pin edge chosen by edge-select bit
`timescale 1ns/1ps
module intc_core #(
  parameter logic [4:0] PRIO [intc_pkg::NSRC] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
    5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14}
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [intc_pkg::NSRC-1:0] SRC_REQ_IN,
  input wire logic [3:1] IRQ_PIN_IN,
  input wire logic I_MASK_IN,
  input wire logic INSN_DONE_IN,
  input wire logic BLOCK_MOVE_IN,
  input wire logic [15:0] PC_IN,
  input wire logic [7:0] CODE_WORD_IN,
  input wire logic [15:0] SP_IN,
  input wire logic EXC_RETURN_IN,
  input wire logic [15:0] POP_WORD_IN,
  output logic ENTRY_OUT,
  output logic MASK_SET_OUT,
  output logic STK_WE_OUT,
  output logic [15:0] STK_ADDR_OUT,
  output logic [15:0] STK_DATA_OUT,
  output logic VEC_RD_OUT,
  output logic [15:0] VEC_ADDR_OUT,
  output logic [4:0] VEC_NUM_OUT,
  output logic CODE_LOAD_OUT,
  output logic [7:0] CODE_RESTORE_OUT
);
  import intc_pkg::*;

  // ==========================================
  // Declarations
  logic pready_r, pslverr_r, acc, wr, clr_hit, pf_recent_r, any_pend;
  logic [31:0] prdata_r, rdata;
  logic map_ok;
  logic [NSRC-1:0] req_r, en_r, pend, clr_req;
  logic [3:1] pf_r, pf_d_r, es_r, preq_r, pen_r, ppend, pclr;
  logic [3:1] pin_s1_r, pin_s2_r, pin_d_r, rise, fall, edge_hit, spur;
  st_t st_r;
  logic [3:0] cnt_r, wait_r;
  logic [4:0] vec_r, sel_vec;
  logic [15:0] base_r, pc_r, stk_addr_r, stk_data_r, vec_addr_r;
  logic [7:0] code_r, code_rest_r;
  logic busy_r, mask_set_r, stk_we_r, vec_rd_r, code_load_r;

  // ==========================================
  // APB slave
  assign acc = PSEL_IN & PENABLE_IN & pready_r;
  assign wr = acc & PWRITE_IN;

  always_comb begin
    map_ok = 1'b1;
    case (PADDR_IN)
      OFS_REQ_ONE: rdata = 32'(req_r[ONE_BITS-1:0]);
      OFS_REQ_TWO: rdata = 32'(req_r[NSRC-1:ONE_BITS]);
      OFS_EN_ONE: rdata = 32'(en_r[ONE_BITS-1:0]);
      OFS_EN_TWO: rdata = 32'(en_r[NSRC-1:ONE_BITS]);
      OFS_PIN_FUNC: rdata = 32'({pf_r, 1'b0});
      OFS_EDGE_SEL: rdata = 32'({es_r, 1'b0});
      OFS_PIN_REQ: rdata = 32'({preq_r, 1'b0});
      OFS_PIN_EN: rdata = 32'({pen_r, 1'b0});
      OFS_STATUS: rdata = 32'({busy_r, st_r, vec_r});
      default: begin
        rdata = 32'h0000_0000;
        map_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= PSEL_IN & PENABLE_IN & ~pready_r;
      pslverr_r <= PSEL_IN & PENABLE_IN & ~pready_r & ~map_ok;
      prdata_r <= (PSEL_IN & PENABLE_IN & ~pready_r) ? rdata : 32'h0000_0000;
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      en_r <= RST_FLAGS;
      pf_r <= RST_PIN;
      es_r <= RST_PIN;
      pen_r <= RST_PIN;
      pf_d_r <= RST_PIN;
    end else begin
      pf_d_r <= pf_r;
      if (wr && PADDR_IN == OFS_EN_ONE) begin
        en_r[ONE_BITS-1:0] <= PWDATA_IN[ONE_BITS-1:0];
      end
      if (wr && PADDR_IN == OFS_EN_TWO) begin
        en_r[NSRC-1:ONE_BITS] <= PWDATA_IN[TWO_BITS-1:0];
      end
      if (wr && PADDR_IN == OFS_PIN_FUNC) begin
        pf_r <= PWDATA_IN[3:1];
      end
      if (wr && PADDR_IN == OFS_EDGE_SEL) begin
        es_r <= PWDATA_IN[3:1];
      end
      if (wr && PADDR_IN == OFS_PIN_EN) begin
        pen_r <= PWDATA_IN[3:1];
      end
    end
  end

  // ==========================================
  // Internal request flags
  always_comb begin
    clr_req = '0;
    if (wr && PADDR_IN == OFS_REQ_ONE) begin
      clr_req[ONE_BITS-1:0] = ~PWDATA_IN[ONE_BITS-1:0];
    end
    if (wr && PADDR_IN == OFS_REQ_TWO) begin
      clr_req[NSRC-1:ONE_BITS] = ~PWDATA_IN[TWO_BITS-1:0];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      req_r <= RST_FLAGS;
    end else begin
      req_r <= (req_r & ~clr_req) | SRC_REQ_IN;
    end
  end

  // ==========================================
  // Pin edge detection
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      pin_d_r <= PIN_IDLE;
    end else begin
      pin_s1_r <= IRQ_PIN_IN;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign rise = pin_s2_r & ~pin_d_r;
  assign fall = ~pin_s2_r & pin_d_r;
  assign edge_hit = pf_r & ((es_r & rise) | (~es_r & fall));
  assign spur = ~pin_s2_r & ((pf_r & ~pf_d_r & ~es_r) | (~pf_r & pf_d_r & es_r));
  assign pclr = (wr && PADDR_IN == OFS_PIN_REQ && !pf_recent_r) ? ~PWDATA_IN[3:1] : RST_PIN;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      pf_recent_r <= 1'b0;
    end else if (acc) begin
      pf_recent_r <= wr && PADDR_IN == OFS_PIN_FUNC;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      preq_r <= RST_PIN;
    end else begin
      preq_r <= (preq_r & ~pclr) | edge_hit | spur;
    end
  end

  // ==========================================
  // Priority selection
  // Enable gating
  assign pend = req_r & en_r;
  assign ppend = preq_r & pen_r;
  assign clr_hit = wr && (PADDR_IN == OFS_REQ_ONE || PADDR_IN == OFS_REQ_TWO ||
    PADDR_IN == OFS_EN_ONE || PADDR_IN == OFS_EN_TWO ||
    PADDR_IN == OFS_PIN_REQ || PADDR_IN == OFS_PIN_EN);

  always_comb begin
    any_pend = 1'b0;
    sel_vec = 5'h00;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (pend[PRIO[k]]) begin
        any_pend = 1'b1;
        sel_vec = vec_of(int'(PRIO[k]));
      end
    end
    for (int p = PIN_HI; p >= PIN_LO; p--) begin
      if (ppend[p]) begin
        any_pend = 1'b1;
        sel_vec = 5'(int'(VEC_PIN_ONE) + p - PIN_LO);
      end
    end
  end

  // ==========================================
  // Exception entry sequencer
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      wait_r <= 4'h0;
      vec_r <= 5'h00;
      base_r <= 16'h0000;
      pc_r <= 16'h0000;
      code_r <= 8'h00;
      busy_r <= 1'b0;
      mask_set_r <= 1'b0;
      stk_we_r <= 1'b0;
      stk_addr_r <= 16'h0000;
      stk_data_r <= 16'h0000;
      vec_rd_r <= 1'b0;
      vec_addr_r <= 16'h0000;
    end else begin
      mask_set_r <= 1'b0;
      stk_we_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          wait_r <= 4'h1;
          if (any_pend && !I_MASK_IN) begin
            st_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (I_MASK_IN || !any_pend) begin
            st_r <= ST_IDLE;
          end else if (!clr_hit &&
              (INSN_DONE_IN || (wait_r == WAIT_MAX && !BLOCK_MOVE_IN))) begin
            st_r <= ST_SAVE;
            vec_r <= sel_vec;
            vec_addr_r <= {10'h000, sel_vec, 1'b0};
            base_r <= SP_IN;
            pc_r <= PC_IN;
            code_r <= CODE_WORD_IN;
            cnt_r <= 4'h0;
            busy_r <= 1'b1;
            mask_set_r <= 1'b1;
          end else if (wait_r != WAIT_MAX) begin
            wait_r <= wait_r + 4'h1;
          end
        end
        ST_SAVE: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h0) begin
            stk_we_r <= 1'b1;
            stk_addr_r <= (base_r - PC_SLOT) & 16'hfffe;
            stk_data_r <= pc_r;
          end
          if (cnt_r == 4'h2) begin
            stk_we_r <= 1'b1;
            stk_addr_r <= (base_r - CODE_SLOT) & 16'hfffe;
            stk_data_r <= {code_r, code_r};
          end
          if (cnt_r == SAVE_STATES - 4'h1) begin
            st_r <= ST_VFETCH;
            cnt_r <= 4'h0;
            vec_rd_r <= 1'b1;
          end
        end
        ST_VFETCH: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == VEC_STATES - 4'h1) begin
            st_r <= ST_IFETCH;
            cnt_r <= 4'h0;
            vec_rd_r <= 1'b0;
          end
        end
        ST_IFETCH: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == IFETCH_STATES - 4'h1) begin
            st_r <= ST_INTERNAL;
            cnt_r <= 4'h0;
          end
        end
        ST_INTERNAL: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == INTERNAL_STATES - 4'h1) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Condition code restore
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      code_load_r <= 1'b0;
      code_rest_r <= 8'h00;
    end else begin
      code_load_r <= EXC_RETURN_IN;
      if (EXC_RETURN_IN) begin
        code_rest_r <= POP_WORD_IN[15:8];
      end
    end
  end

  // ==========================================
  // Outputs
  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
  assign ENTRY_OUT = busy_r;
  assign MASK_SET_OUT = mask_set_r;
  assign STK_WE_OUT = stk_we_r;
  assign STK_ADDR_OUT = stk_addr_r;
  assign STK_DATA_OUT = stk_data_r;
  assign VEC_RD_OUT = vec_rd_r;
  assign VEC_ADDR_OUT = vec_addr_r;
  assign VEC_NUM_OUT = vec_r;
  assign CODE_LOAD_OUT = code_load_r;
  assign CODE_RESTORE_OUT = code_rest_r;

  // ==========================================
  // Assertions
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence s_save;
    (st_r == ST_SAVE) [*4];
  endsequence
  sequence s_vec;
    (st_r == ST_VFETCH && VEC_RD_OUT) [*2];
  endsequence
  sequence s_tail;
    (st_r == ST_IFETCH) [*4] ##1 (st_r == ST_INTERNAL) [*4];
  endsequence

  property p_entry;
    MASK_SET_OUT |-> s_save ##1 s_vec ##1 s_tail ##1 st_r == ST_IDLE;
  endproperty
  a_entry: assert property (p_entry) else $error("entry phase lengths wrong");

  property p_mask;
    $rose(st_r == ST_SAVE) |-> MASK_SET_OUT && !$past(I_MASK_IN);
  endproperty
  a_mask: assert property (p_mask) else $error("entry without mask set");

  property p_masked;
    (st_r == ST_WAIT && I_MASK_IN) |=> st_r == ST_IDLE;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request accepted");

  property p_wait_bound;
    (st_r == ST_WAIT && wait_r == WAIT_MAX && any_pend && !I_MASK_IN && !clr_hit
      && !BLOCK_MOVE_IN) |=> st_r == ST_SAVE;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("wait exceeded");

  property p_even;
    STK_WE_OUT |-> !STK_ADDR_OUT[0] ##1 !STK_WE_OUT;
  endproperty
  a_even: assert property (p_even) else $error("odd stack address");

  property p_vec_addr;
    VEC_RD_OUT |-> VEC_ADDR_OUT == {10'h000, VEC_NUM_OUT, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address mismatch");

  property p_sticky;
    !(wr && (PADDR_IN == OFS_REQ_ONE || PADDR_IN == OFS_REQ_TWO))
      |=> (req_r & $past(req_r)) == $past(req_r);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without write");

  property p_pin_hold;
    (wr && PADDR_IN == OFS_PIN_REQ && pf_recent_r) |=> (preq_r & $past(preq_r)) == $past(preq_r);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("clear after function write");

  property p_spur;
    (~pin_s2_r[2] && pf_r[2] && !pf_d_r[2] && !es_r[2]) |=> preq_r[2];
  endproperty
  a_spur: assert property (p_spur) else $error("switch flag not set");

  property p_restore;
    EXC_RETURN_IN |=> CODE_LOAD_OUT && CODE_RESTORE_OUT == $past(POP_WORD_IN[15:8]);
  endproperty
  a_restore: assert property (p_restore) else $error("wrong restore byte");
endmodule : intc_core

// File: bench/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] len_in,
  input wire logic sw_we_in,
  input wire logic sw_mask_in,
  input wire logic entry_in,
  input wire logic mask_set_in,
  input wire logic code_load_in,
  input wire logic [7:0] code_restore_in,
  output logic mask_out,
  output logic done_out,
  output logic [15:0] pc_out,
  output logic [7:0] code_out,
  output logic [15:0] sp_out
);
  logic [3:0] cnt_r;
  // ==========================================
  // Instruction pacing
  // instruction ends, counter moves on
  assign done_out = !entry_in && (cnt_r >= len_in);
  always_ff @(posedge clk_in) begin
    if (rst_in || entry_in || done_out) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) pc_out <= 16'h0100;
    else if (done_out) pc_out <= pc_out + 16'h0002;
  end
  // ==========================================
  // Mask bit
  // set on entry, loaded on return
  always_ff @(posedge clk_in) begin
    if (rst_in || mask_set_in) mask_out <= 1'b1;
    else if (code_load_in) mask_out <= code_restore_in[7];
    else if (sw_we_in) mask_out <= sw_mask_in;
  end
  assign code_out = {mask_out, 7'h2a};
  assign sp_out = 16'h0ff0;
endmodule : cpu_model

// File: bench/tb_interrupt_accept_control.sv
`timescale 1ns/1ps
module tb_interrupt_accept_control;
  import intc_pkg::*;
  typedef struct {logic [NSRC-1:0] req; int idx; logic [4:0] vec; logic [3:0] len;} row_t;
  row_t rows [9] = '{
    '{21'h00_0001, 0, 5'h09, 4'h1}, '{21'h00_0020, 5, 5'h0e, 4'h3},
    '{21'h00_2000, 13, 5'h16, 4'h6}, '{21'h00_4000, 14, 5'h17, 4'h2},
    '{21'h10_0000, 20, 5'h17, 4'h4}, '{21'h00_0088, 3, 5'h0c, 4'h1},
    '{21'h00_0000, 7, 5'h10, 4'h2}, '{21'h00_0050, 6, 5'h0f, 4'h1},
    '{21'h00_0000, 4, 5'h0d, 4'h5}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, ret = 1'b0, sw_we = 1'b0, sw_mask = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [NSRC-1:0] src = '0;
  logic [3:1] pins = PIN_IDLE;
  logic [15:0] pop = 16'h0000;
  logic [3:0] len = 4'h1;
  logic mask, done, entry, mset, we, vrd, cload, rdy, err, e;
  logic [31:0] prdata, rd;
  logic [15:0] saddr, sdata, vaddr, pc, sp, last_pc;
  logic [7:0] codes, crest;
  logic [4:0] vnum;
  int fails = 0, checked = 0, entries = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (done === 1'b1) last_pc <= pc;
    if (mset === 1'b1) entries <= entries + 1;
  end
  intc_core intc_core_inst (.REF_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .SRC_REQ_IN(src),
    .IRQ_PIN_IN(pins), .I_MASK_IN(mask), .INSN_DONE_IN(done), .BLOCK_MOVE_IN(1'b0),
    .PC_IN(pc), .CODE_WORD_IN(codes), .SP_IN(sp), .EXC_RETURN_IN(ret), .POP_WORD_IN(pop),
    .ENTRY_OUT(entry), .MASK_SET_OUT(mset), .STK_WE_OUT(we), .STK_ADDR_OUT(saddr),
    .STK_DATA_OUT(sdata), .VEC_RD_OUT(vrd), .VEC_ADDR_OUT(vaddr), .VEC_NUM_OUT(vnum),
    .CODE_LOAD_OUT(cload), .CODE_RESTORE_OUT(crest));
  cpu_model cpu_model_inst (.clk_in(clk), .rst_in(rst), .len_in(len), .sw_we_in(sw_we),
    .sw_mask_in(sw_mask), .entry_in(entry), .mask_set_in(mset), .code_load_in(cload),
    .code_restore_in(crest), .mask_out(mask), .done_out(done), .pc_out(pc),
    .code_out(codes), .sp_out(sp));
  // ==========================================
  // Helpers
  task automatic close_out();
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd_is(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, x);
  endtask : rd_is
  task automatic run_entry(input row_t r);
    int n, pu, vr, ms, b;
    logic [7:0] fa;
    len <= r.len;
    src <= r.req;
    @(posedge clk);
    src <= '0;
    n = entries;
    tick(20);
    check(32'(entries), 32'(n));
    pop <= 16'h00ff;
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    n = 0;
    while (cload !== 1'b1 && n < 5) begin
      @(posedge clk);
      n++;
    end
    check(32'(crest), 32'h0000_0000);
    n = 0;
    while (entry !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(32'(n < 16), 32'h0000_0001);
    n = 0;
    pu = 0;
    vr = 0;
    ms = 0;
    while (entry === 1'b1 && n < 40) begin
      if (mset === 1'b1) ms++;
      if (we === 1'b1) begin
        check({saddr, sdata}, pu == 0 ? {16'h0fee, last_pc} : 32'h0fec_2a2a);
        pu++;
      end
      if (vrd === 1'b1) begin
        check({vnum, 11'h000, vaddr}, {r.vec, 21'h00_0000, r.vec, 1'b0});
        vr++;
      end
      @(posedge clk);
      n++;
    end
    check(32'(n), 32'd14);
    check({pu[15:0], vr[15:0]}, 32'h0002_0002);
    check(32'({ms[3:0], 3'h0, mask}), 32'h0000_0011);
    fa = r.idx < 16 ? OFS_REQ_ONE : OFS_REQ_TWO;
    b = r.idx % 16;
    apb(1'b0, fa, 32'h0000_0000);
    check(32'(rd[b]), 32'h0000_0001);
    apb(1'b1, fa, ~(32'h0000_0001 << b));
    apb(1'b0, fa, 32'h0000_0000);
    check(32'(rd[b]), 32'h0000_0000);
  endtask : run_entry
  // ==========================================
  // Sequence
  initial begin
    #500_000;
    fails++;
    close_out();
  end
  initial begin
    tick(20);
    rst <= 1'b0;
    @(posedge clk);
    rd_is(OFS_REQ_ONE, 32'(RST_FLAGS[ONE_BITS-1:0]));
    rd_is(OFS_REQ_TWO, 32'(RST_FLAGS[NSRC-1:ONE_BITS]));
    rd_is(OFS_PIN_REQ, 32'({RST_PIN, 1'b0}));
    apb(1'b1, OFS_EN_ONE, 32'h0000_ffff);
    apb(1'b1, OFS_EN_TWO, 32'h0000_001f);
    for (int i = 0; i < 7; i++) run_entry(rows[i]);
    apb(1'b1, OFS_EN_ONE, 32'h0000_ffef);
    run_entry(rows[7]);
    apb(1'b1, OFS_EN_ONE, 32'h0000_ffff);
    run_entry(rows[8]);
    apb(1'b1, OFS_EDGE_SEL, 32'h0000_0008);
    apb(1'b1, OFS_PIN_FUNC, 32'h0000_000a);
    pins <= 3'b110;
    tick(6);
    rd_is(OFS_PIN_REQ, 32'h0000_0002);
    apb(1'b1, OFS_PIN_REQ, 32'h0000_0000);
    pins <= 3'b100;
    tick(6);
    apb(1'b1, OFS_PIN_FUNC, 32'h0000_000e);
    apb(1'b1, OFS_PIN_REQ, 32'h0000_0000);
    rd_is(OFS_PIN_REQ, 32'h0000_0004);
    apb(1'b1, OFS_PIN_REQ, 32'h0000_0000);
    rd_is(OFS_PIN_REQ, 32'h0000_0000);
    pins <= 3'b000;
    tick(6);
    apb(1'b1, OFS_PIN_FUNC, 32'h0000_0006);
    tick(4);
    rd_is(OFS_PIN_REQ, 32'h0000_0008);
    pins <= PIN_IDLE;
    apb(1'b0, 8'h24, 32'h0000_0000);
    check({rd[30:0], e}, 32'h0000_0001);
    src <= 21'h00_0200;
    @(posedge clk);
    src <= '0;
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    @(posedge clk);
    rd_is(OFS_REQ_ONE, 32'h0000_0000);
    rd_is(OFS_STATUS, 32'h0000_0000);
    check(32'(entry), 32'h0000_0000);
    close_out();
  end
endmodule : tb_interrupt_accept_control
